// ==== bench/cpuc_chipset_model.sv ====
`timescale 1ns/1ps
module cpuc_chipset_model (
   // clock
   input  wire logic       aclk,
   // bench commands: 0 awake, 1 suspend, 2 soft-off; module type number
   input  wire logic [1:0] sleep_cmd,
   input  wire logic [2:0] type_sel,
   // board side
   input  wire logic       module_button_n,
   output logic            suspend_ram_n,
   output logic            soft_off_n,
   output logic            pinout_code_b0_n,
   output logic            pinout_code_b1_n,
   output logic            pinout_code_b2_n
);
   logic woken;

   // wake on button
   // a press while asleep releases sleep until the bench wakes us itself
   always_ff @(posedge aclk) begin
      if (sleep_cmd == 2'h0)
         woken <= 1'b0;
      else if (!module_button_n)
         woken <= 1'b1;
   end

   assign suspend_ram_n = !(sleep_cmd != 2'h0 && !woken);
   assign soft_off_n    = !(sleep_cmd == 2'h2 && !woken);

   assign pinout_code_b0_n = 1'b1;
   assign pinout_code_b1_n = !(type_sel == 3'h4 || type_sel == 3'h5);
   assign pinout_code_b2_n = !(type_sel == 3'h3 || type_sel == 3'h5);
endmodule

// ==== bench/cpuc_top_tb_top.sv ====
`timescale 1ns/1ps
module cpuc_top_tb_top;
   localparam int PLEN = 4;
   logic        aclk, aresetn, sleep_source_strap, powerup_source_strap, front_button_n;
   logic [1:0]  sleep_cmd, s_axi_bresp, s_axi_rresp;
   logic [2:0]  type_sel;
   logic        suspend_ram_n, soft_off_n, supply_on_n, module_button_n, mismatch_led, irq;
   logic        pinout_code_b0_n, pinout_code_b1_n, pinout_code_b2_n;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          num_errors = 0;
   int          checked = 0;

   cpuc_top #(.PULSE_LEN(PLEN)) u_cpuc_top (
      .aclk, .aresetn, .suspend_ram_n, .soft_off_n, .sleep_source_strap,
      .powerup_source_strap, .pinout_code_b0_n, .pinout_code_b1_n, .pinout_code_b2_n,
      .front_button_n, .supply_on_n, .module_button_n, .mismatch_led, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );

   cpuc_chipset_model u_cpuc_chipset_model (
      .aclk, .sleep_cmd, .type_sel, .module_button_n, .suspend_ram_n, .soft_off_n,
      .pinout_code_b0_n, .pinout_code_b1_n, .pinout_code_b2_n
   );

   // 50 MHz clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task check_bit(input logic got, input logic exp, input string msg);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task summarize;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // straps are latched once after reset, so every mode change needs one
   task do_reset(input logic pwr, input logic slp, input logic [2:0] ty);
      @(posedge aclk);
      aresetn <= 1'b0;
      powerup_source_strap <= pwr;
      sleep_source_strap <= slp;
      type_sel <= ty;
      sleep_cmd <= 2'h0;
      front_button_n <= 1'b1;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
   endtask

   // supply follows its cause within three cycles; eight leaves margin
   task expect_supply(input logic exp, input string msg);
      repeat (8) @(posedge aclk);
      check_bit(supply_on_n, exp, msg);
   endtask

   task press;
      front_button_n <= 1'b0;
      repeat (6) @(posedge aclk);
      front_button_n <= 1'b1;
   endtask

   task axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      r = 2'h1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung answer
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   task axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      r = 2'h1;
      d = 32'h0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   task t_regs;
      logic [31:0] d;
      logic [1:0] r;
      do_reset(1'b0, 1'b0, 3'h2);
      axi_rd(cpuc_pkg::REG_ENABLE, d, r);
      check_word(d, {27'h0, cpuc_pkg::ENABLE_RESET}, "enable reset");
      axi_rd(cpuc_pkg::REG_STATE, d, r);
      check_word(d & 32'hFF, (32'h1 << cpuc_pkg::ST_READY) | (32'h2 << cpuc_pkg::ST_TYPE_LO)
                 | (32'h1 << cpuc_pkg::ST_SUPPLY), "state");
      check_bit(mismatch_led, 1'b0, "led pinout_code_b2_n");
      axi_rd(cpuc_pkg::REG_CLEAR, d, r);
      check_word(d, 32'h0, "clear reads");
      axi_rd(5'h14, d, r);
      check_word({d[29:0], r}, {30'h0, cpuc_pkg::RESP_SLVERR}, "unmapped read");
      axi_wr(5'h10, 32'hFFFFFFFF, r);
      check_word({30'h0, r}, {30'h0, cpuc_pkg::RESP_SLVERR}, "unmapped write");
   endtask

   task t_irq;
      logic [31:0] d;
      logic [1:0] r;
      do_reset(1'b0, 1'b0, 3'h2);
      axi_wr(cpuc_pkg::REG_ENABLE, 32'h1 << cpuc_pkg::EV_SLEEP, r);
      check_bit(irq, 1'b0, "irq idle");
      sleep_cmd <= 2'h1;
      expect_supply(1'b1, "suspend off");
      check_bit(irq, 1'b1, "irq sleep");
      axi_rd(cpuc_pkg::REG_STATUS, d, r);
      check_word(d & (32'h1 << cpuc_pkg::EV_SLEEP), 32'h1 << cpuc_pkg::EV_SLEEP, "status");
      axi_wr(cpuc_pkg::REG_CLEAR, 32'h1 << cpuc_pkg::EV_SLEEP, r);
      repeat (2) @(posedge aclk);
      check_bit(irq, 1'b0, "irq cleared");
      sleep_cmd <= 2'h0;
      expect_supply(1'b0, "wake on");
      check_bit(irq, 1'b0, "wake masked");
   endtask

   task t_module;
      for (int s = 0; s < 2; s++) begin
         do_reset(1'b0, s[0], 3'h2);
         expect_supply(1'b0, "awake on");
         sleep_cmd <= 2'h1;
         expect_supply(s == 0, "suspend strap");
         sleep_cmd <= 2'h2;
         expect_supply(1'b1, "soft-off off");
         front_button_n <= 1'b0;
         repeat (5) @(posedge aclk);
         check_bit(module_button_n, 1'b0, "button to module");
         front_button_n <= 1'b1;
         expect_supply(1'b0, "woken on");
         sleep_cmd <= 2'h0;
      end
   endtask

   task t_ctl;
      int n;
      int w;
      n = 0;
      w = 0;
      do_reset(1'b1, 1'b0, 3'h2);
      expect_supply(1'b1, "ctl starts off");
      front_button_n <= 1'b0;
      while (module_button_n !== 1'b0 && n < 20) begin
         @(posedge aclk);
         n++;
      end
      check_bit(supply_on_n, 1'b0, "press on");
      while (module_button_n === 1'b0 && w < 20) begin
         @(posedge aclk);
         w++;
      end
      check_word(w, PLEN, "pulse len");
      front_button_n <= 1'b1;
      sleep_cmd <= 2'h1;
      expect_supply(1'b1, "ctl suspend off");
      sleep_cmd <= 2'h0;
      expect_supply(1'b0, "ctl resume on");
      sleep_cmd <= 2'h2;
      expect_supply(1'b1, "ctl soft-off off");
      press();
      expect_supply(1'b0, "ctl wake on");
      sleep_cmd <= 2'h0;
   endtask

   task t_types;
      for (int t = 3; t < 6; t++) begin
         for (int p = 0; p < 2; p++) begin
            do_reset(p[0], 1'b0, t[2:0]);
            check_bit(mismatch_led, 1'b1, "led bad type");
            press();
            expect_supply(1'b1, "bad type off");
         end
      end
   endtask

   initial begin
      aresetn = 1'b0;
      sleep_cmd = 2'h0;
      type_sel = 3'h2;
      sleep_source_strap = 1'b0;
      powerup_source_strap = 1'b0;
      front_button_n = 1'b1;
      s_axi_awaddr = 5'h00;
      s_axi_araddr = 5'h00;
      s_axi_wdata = 32'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      t_regs();
      t_irq();
      t_module();
      t_ctl();
      t_types();
      summarize();
   end

   // watchdog, over thirty times the expected run
   initial begin
      repeat (20000) @(posedge aclk);
      $display("MISMATCH %0t watchdog", $time);
      num_errors++;
      summarize();
   end
endmodule

// ==== logic/cpuc_pkg.sv ====
package cpuc_pkg;

   // register map, byte addresses on the AXI4-Lite port
   localparam int         ADDR_W      = 5;
   localparam logic [4:0] REG_STATUS  = 5'h00;
   localparam logic [4:0] REG_CLEAR   = 5'h04;
   localparam logic [4:0] REG_ENABLE  = 5'h08;
   localparam logic [4:0] REG_STATE   = 5'h0C;

   // event bits, same layout in status, clear and enable
   localparam int EV_W      = 5;
   localparam int EV_BUTTON = 0;
   localparam int EV_SLEEP  = 1;
   localparam int EV_WAKE   = 2;
   localparam int EV_BADMOD = 3;
   localparam int EV_PWRON  = 4;
   localparam logic [EV_W-1:0] ENABLE_RESET = 5'h00;

   // state register fields
   localparam int ST_SUPPLY   = 0;
   localparam int ST_MISMATCH = 1;
   localparam int ST_PWR_SRC  = 2;
   localparam int ST_SLP_SRC  = 3;
   localparam int ST_TYPE_LO  = 4;
   localparam int ST_READY    = 7;
   localparam int ST_CTL_ON   = 8;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // pinout code {bit2, bit1, bit0}, open pin reads one
   localparam logic [2:0] CODE_PINOUT_CODE_B2_N = 3'h7;
   localparam logic [2:0] CODE_TYPE3 = 3'h3;
   localparam logic [2:0] CODE_TYPE4 = 3'h5;
   localparam logic [2:0] CODE_TYPE5 = 3'h1;
   localparam logic [2:0] TYPE_NONE  = 3'h0;
   localparam logic [7:0] COMPAT_DEFAULT = 8'h04;

   // synchroniser lanes and their reset levels
   localparam int SY_W     = 8;
   localparam int SY_PWR   = 0;
   localparam int SY_SLP   = 1;
   localparam int SY_SUSP  = 2;
   localparam int SY_SOFT  = 3;
   localparam int SY_FRONT = 4;
   localparam int SY_CODE  = 5;
   localparam logic [SY_W-1:0] SYNC_RESET = 8'hFC;

   // timing
   localparam int CLK_FREQ_HZ     = 50000000;
   localparam int BUTTON_PULSE_US = 20;
   localparam int PULSE_CYCLES    = (BUTTON_PULSE_US * CLK_FREQ_HZ + 999999) / 1000000;
   localparam int PULSE_W         = 10;
   localparam logic [1:0] SETTLE_LAST = 2'h3;

   typedef enum logic {
      PH_SETTLE,
      PH_RUN
   } cpuc_phase_t;

endpackage

// ==== logic/cpuc_sync.sv ====
`timescale 1ns/1ps
module cpuc_sync #(
   parameter int                W         = 8,
   parameter logic [W-1:0]      RESET_VAL = '0
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // raw and synchronised levels
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] synced
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } cpuc_sync_t;

   cpuc_sync_t s_reg;
   cpuc_sync_t s_next;

   // meta is read only by the second stage
   always_comb begin
      s_next        = s_reg;
      s_next.meta   = raw;
      s_next.stable = s_reg.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= {RESET_VAL, RESET_VAL};
      end else begin
         s_reg <= s_next;
      end
   end

   assign synced = s_reg.stable;

endmodule

// ==== logic/cpuc_top.sv ====
`timescale 1ns/1ps
// How it works
// (RQ1) module mode: supply request is inverted sleep
// (RQ2) chipset releases sleep on wake events
// (RQ3) strap picks suspend or soft-off sleep source
// (RQ4) strap picks module or controller power source
// (RQ5) front button inverted into controller sense
// (RQ6) button event pulses module button low
// (RQ7) button event also switches supply on
// (RQ8) controller sleep follows suspend, asserting turns off
// (RQ9) suspend release switches supply back on
// (RQ10) module grounds type pins to encode type
// (RQ11) type one needs no code, pins ignored
// (RQ12) incompatible type holds supply off always
// (RQ13) incompatible type lights red indicator
// (RQ14) supply request low means supply on
// (RQ15) compatible types are a parameter, type two
// (RQ16) inputs synchronised, supply output registered
module cpuc_top #(
   parameter logic [7:0] COMPAT_MASK = cpuc_pkg::COMPAT_DEFAULT,
   parameter int         PULSE_LEN   = cpuc_pkg::PULSE_CYCLES
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // module sleep states and straps
   input  wire logic        suspend_ram_n,
   input  wire logic        soft_off_n,
   input  wire logic        sleep_source_strap,
   input  wire logic        powerup_source_strap,
   // module pinout code
   input  wire logic        pinout_code_b0_n,
   input  wire logic        pinout_code_b1_n,
   input  wire logic        pinout_code_b2_n,
   // front panel and supply
   input  wire logic        front_button_n,
   output logic             supply_on_n,
   output logic             module_button_n,
   output logic             mismatch_led,
   output logic             irq,
   // axi4-lite write
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   localparam int EW = cpuc_pkg::EV_W;
   localparam int PW = cpuc_pkg::PULSE_W;

   typedef struct packed {
      cpuc_pkg::cpuc_phase_t phase;
      logic [1:0]            settle;
      logic                  sleep_src;
      logic                  pwr_src;
      logic                  sense_d;
      logic                  sleep_d;
      logic                  ctl_on;
      logic [PW-1:0]         pulse_cnt;
      logic                  button_out_n;
      logic                  module_button_n;
      logic                  supply_on_n;
      logic                  mismatch;
      logic [2:0]            mod_type;
      logic [EW-1:0]         status;
      logic [EW-1:0]         enable;
      logic                  irq;
      logic                  awready;
      logic                  wready;
      logic                  aw_got;
      logic                  w_got;
      logic [4:0]            awaddr;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
   } cpuc_state_t;

   cpuc_state_t st_reg;
   cpuc_state_t st_next;

   logic [cpuc_pkg::SY_W-1:0] sy;

   // every board pin is synchronised before use; the axi port is used as is
   cpuc_sync #(
      .W         (cpuc_pkg::SY_W),
      .RESET_VAL (cpuc_pkg::SYNC_RESET)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .raw     ({pinout_code_b2_n, pinout_code_b1_n, pinout_code_b0_n, front_button_n,
                 soft_off_n, suspend_ram_n, sleep_source_strap, powerup_source_strap}),
      .synced  (sy)
   );

   // pinout code to type number, unknown codes give none
   function automatic logic [2:0] cpuc_decode(input logic [2:0] code);
      logic [2:0] t;
      t = cpuc_pkg::TYPE_NONE;
      case (code)
         cpuc_pkg::CODE_PINOUT_CODE_B2_N: t = 3'h2;
         cpuc_pkg::CODE_TYPE3: t = 3'h3;
         cpuc_pkg::CODE_TYPE4: t = 3'h4;
         cpuc_pkg::CODE_TYPE5: t = 3'h5;
         default:              t = cpuc_pkg::TYPE_NONE;
      endcase
      return t;
   endfunction

   // byte-lane merge of a write into a narrow register
   function automatic logic [EW-1:0] cpuc_merge(input logic [EW-1:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0]  strb);
      logic [31:0] w;
      w = {{(32-EW){1'b0}}, old};
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            w[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return w[EW-1:0];
   endfunction

   // combinational inputs to the sequencer
   logic [2:0]    code_now;
   logic [2:0]    type_now;
   logic          bad_now;
   logic          sense;
   logic          sel_sleep;
   logic          btn_edge;
   logic          slp_fall;
   logic          slp_rise;
   logic [EW-1:0] ev_set;
   logic [EW-1:0] ev_clr;
   logic          wr_do;
   logic [31:0]   rd_word;

   always_comb begin
      st_next  = st_reg;
      code_now = sy[cpuc_pkg::SY_CODE +: 3];
      // (RQ11) type one ignored
      // type one modules carry no code, so nothing here can name them
      type_now = cpuc_decode(code_now);
      // (RQ15) compatible type mask
      bad_now  = !COMPAT_MASK[type_now];
      // (RQ5) button sense inverted
      sense    = !sy[cpuc_pkg::SY_FRONT];
      // (RQ3) sleep source select
      // (RQ8) controller follows suspend
      if (st_reg.pwr_src) begin
         sel_sleep = sy[cpuc_pkg::SY_SUSP];
      end else if (st_reg.sleep_src) begin
         sel_sleep = sy[cpuc_pkg::SY_SOFT];
      end else begin
         sel_sleep = sy[cpuc_pkg::SY_SUSP];
      end
      btn_edge = (st_reg.phase == cpuc_pkg::PH_RUN) && sense && !st_reg.sense_d;
      slp_fall = (st_reg.phase == cpuc_pkg::PH_RUN) && !sel_sleep && st_reg.sleep_d;
      slp_rise = (st_reg.phase == cpuc_pkg::PH_RUN) && sel_sleep && !st_reg.sleep_d;
      st_next.sense_d  = sense;
      st_next.sleep_d  = sel_sleep;
      st_next.mod_type = type_now;

      // straps are static: caught once the synchroniser has settled
      case (st_reg.phase)
         cpuc_pkg::PH_SETTLE: begin
            st_next.settle = st_reg.settle + 2'h1;
            if (st_reg.settle == cpuc_pkg::SETTLE_LAST) begin
               // (RQ4) power source strap
               st_next.pwr_src   = sy[cpuc_pkg::SY_PWR];
               st_next.sleep_src = sy[cpuc_pkg::SY_SLP];
               st_next.phase     = cpuc_pkg::PH_RUN;
            end
         end
         cpuc_pkg::PH_RUN: begin
            st_next.settle = st_reg.settle;
         end
         default: begin
            st_next.phase = cpuc_pkg::PH_SETTLE;
         end
      endcase

      // (RQ6) button pulse to module
      if (btn_edge && st_reg.pwr_src) begin
         st_next.pulse_cnt    = PW'(PULSE_LEN - 1);
         st_next.button_out_n = 1'b0;
      end else if (st_reg.pulse_cnt != '0) begin
         st_next.pulse_cnt = st_reg.pulse_cnt - PW'(1);
      end else begin
         st_next.button_out_n = 1'b1;
      end

      // controller power state: sleep entry wins over a coincident press
      // (RQ7) button turns supply on
      // (RQ9) wake turns supply on
      if (st_reg.pwr_src && (btn_edge || slp_rise)) begin
         st_next.ctl_on = 1'b1;
      end
      // (RQ8) sleep turns supply off
      if (st_reg.pwr_src && slp_fall) begin
         st_next.ctl_on = 1'b0;
      end

      // in module mode the front button goes straight to the chipset
      st_next.module_button_n = 1'b1;
      if (st_reg.phase == cpuc_pkg::PH_RUN) begin
         st_next.module_button_n = st_reg.pwr_src ? st_next.button_out_n
                                                  : sy[cpuc_pkg::SY_FRONT];
      end

      // (RQ13) red indicator
      st_next.mismatch = (st_reg.phase == cpuc_pkg::PH_RUN) && bad_now;
      // (RQ12) incompatible holds off
      // (RQ14) active-low supply request
      // (RQ1) inverted sleep drives supply
      // (RQ16) registered supply output
      if (st_reg.phase != cpuc_pkg::PH_RUN || bad_now) begin
         st_next.supply_on_n = 1'b1;
      end else if (st_reg.pwr_src) begin
         st_next.supply_on_n = !st_next.ctl_on;
      end else begin
         st_next.supply_on_n = !sel_sleep;
      end

      // sticky events
      ev_set = '0;
      ev_set[cpuc_pkg::EV_BUTTON] = btn_edge;
      ev_set[cpuc_pkg::EV_SLEEP]  = slp_fall;
      ev_set[cpuc_pkg::EV_WAKE]   = slp_rise;
      ev_set[cpuc_pkg::EV_BADMOD] = st_next.mismatch && !st_reg.mismatch;
      ev_set[cpuc_pkg::EV_PWRON]  = !st_next.supply_on_n && st_reg.supply_on_n;

      // axi write: address and data taken in either order
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_got  = 1'b1;
         st_next.awaddr  = s_axi_awaddr;
         st_next.awready = 1'b0;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_got  = 1'b1;
         st_next.wdata  = s_axi_wdata;
         st_next.wstrb  = s_axi_wstrb;
         st_next.wready = 1'b0;
      end
      wr_do  = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
      ev_clr = '0;
      if (wr_do) begin
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = cpuc_pkg::RESP_OKAY;
         case ({st_reg.awaddr[4:2], 2'h0})
            cpuc_pkg::REG_CLEAR: begin
               ev_clr = cpuc_merge('0, st_reg.wdata, st_reg.wstrb);
            end
            cpuc_pkg::REG_ENABLE: begin
               st_next.enable = cpuc_merge(st_reg.enable, st_reg.wdata, st_reg.wstrb);
            end
            cpuc_pkg::REG_STATUS, cpuc_pkg::REG_STATE: begin
               st_next.bresp = cpuc_pkg::RESP_OKAY;
            end
            default: begin
               st_next.bresp = cpuc_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid  = 1'b0;
         st_next.awready = 1'b1;
         st_next.wready  = 1'b1;
      end
      // a new event beats a clear in the same cycle
      st_next.status = (st_reg.status & ~ev_clr) | ev_set;
      st_next.irq    = |(st_next.status & st_next.enable);

      // axi read: one outstanding, answer one cycle after the address
      rd_word = '0;
      case ({s_axi_araddr[4:2], 2'h0})
         cpuc_pkg::REG_STATUS: rd_word[EW-1:0] = st_reg.status;
         cpuc_pkg::REG_ENABLE: rd_word[EW-1:0] = st_reg.enable;
         cpuc_pkg::REG_CLEAR:  rd_word = '0;
         cpuc_pkg::REG_STATE: begin
            rd_word[cpuc_pkg::ST_SUPPLY]   = !st_reg.supply_on_n;
            rd_word[cpuc_pkg::ST_MISMATCH] = st_reg.mismatch;
            rd_word[cpuc_pkg::ST_PWR_SRC]  = st_reg.pwr_src;
            rd_word[cpuc_pkg::ST_SLP_SRC]  = st_reg.sleep_src;
            rd_word[cpuc_pkg::ST_TYPE_LO +: 3] = st_reg.mod_type;
            rd_word[cpuc_pkg::ST_READY]    = (st_reg.phase == cpuc_pkg::PH_RUN);
            rd_word[cpuc_pkg::ST_CTL_ON]   = st_reg.ctl_on;
         end
         default: rd_word = '0;
      endcase
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.arready = 1'b0;
         st_next.rvalid  = 1'b1;
         st_next.rdata   = rd_word;
         st_next.rresp   = (s_axi_araddr[4] == 1'b1) ? cpuc_pkg::RESP_SLVERR
                                                     : cpuc_pkg::RESP_OKAY;
      end
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid  = 1'b0;
         st_next.arready = 1'b1;
      end
   end

   // the whole block state in one register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg              <= '0;
         st_reg.phase        <= cpuc_pkg::PH_SETTLE;
         st_reg.sense_d      <= 1'b0;
         st_reg.sleep_d      <= 1'b1;
         st_reg.button_out_n <= 1'b1;
         st_reg.module_button_n <= 1'b1;
         st_reg.supply_on_n  <= 1'b1;
         st_reg.enable       <= cpuc_pkg::ENABLE_RESET;
         st_reg.awready      <= 1'b1;
         st_reg.wready       <= 1'b1;
         st_reg.arready      <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign supply_on_n     = st_reg.supply_on_n;
   assign module_button_n = st_reg.module_button_n;
   assign mismatch_led    = st_reg.mismatch;
   assign irq             = st_reg.irq;
   assign s_axi_awready   = st_reg.awready;
   assign s_axi_wready    = st_reg.wready;
   assign s_axi_bvalid    = st_reg.bvalid;
   assign s_axi_bresp     = st_reg.bresp;
   assign s_axi_arready   = st_reg.arready;
   assign s_axi_rvalid    = st_reg.rvalid;
   assign s_axi_rdata     = st_reg.rdata;
   assign s_axi_rresp     = st_reg.rresp;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic run;
   assign run = (st_reg.phase == cpuc_pkg::PH_RUN);

   mismatch_off_a: assert property (mismatch_led |-> supply_on_n) // RQ12
      else $error("supply requested with incompatible module");
   led_type_a: assert property (run && !COMPAT_MASK[cpuc_decode(sy[7:5])] |=> mismatch_led) // RQ13
      else $error("indicator not lit for incompatible type");
   mod_suspend_a: assert property (run && !st_reg.pwr_src && !st_reg.sleep_src && !bad_now
                                   |=> supply_on_n == !$past(sy[cpuc_pkg::SY_SUSP])) // RQ1
      else $error("supply not inverse of suspend signal");
   mod_softoff_a: assert property (run && !st_reg.pwr_src && st_reg.sleep_src && !bad_now
                                   |=> supply_on_n == !$past(sy[cpuc_pkg::SY_SOFT])) // RQ3
      else $error("supply not inverse of soft-off signal");
   btn_pulse_a: assert property (btn_edge && st_reg.pwr_src
                                 |=> !module_button_n [*2]) // RQ6
      else $error("module button not pulsed");
   btn_power_a: assert property (btn_edge && st_reg.pwr_src && !slp_fall && !bad_now
                                 |=> !supply_on_n) // RQ7
      else $error("button did not switch supply on");
   sleep_off_a: assert property (slp_fall && st_reg.pwr_src |=> supply_on_n) // RQ8
      else $error("sleep did not switch supply off");
   wake_on_a: assert property (slp_rise && st_reg.pwr_src && !bad_now |=> !supply_on_n) // RQ9
      else $error("wake did not switch supply on");
   irq_level_a: assert property (|(ev_set & st_next.enable) |=> irq) // RQ16
      else $error("enabled event did not raise interrupt");

endmodule
